// *** pbcs_host.sv ***
/* Management host model: one-cycle write and read strobes.
   Assumes the bank samples strobes on the rising edge of sys_clk_i. */
`timescale 1ns/100ps
module pbcs_host (
  input  wire logic        sys_clk_i, // Clock.
  input  wire logic [15:0] rdata_i,   // Read data.
  output logic             wr_o,      // Write strobe.
  output logic             rd_o,      // Read strobe.
  output logic      [4:0]  addr_o,    // Index.
  output logic      [15:0] wdata_o    // Write data.
);
  // Idle lines at time zero.
  initial begin
    {wr_o, rd_o, addr_o, wdata_o} = 23'h0;
  end
  // One write; released lines show the inverse so stale data never matches.
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    {wr_o, addr_o, wdata_o} <= {1'b1, a, d};
    @(posedge sys_clk_i);
    {wr_o, addr_o, wdata_o} <= {1'b0, ~a, ~d};
  endtask
  // One read; the registered answer is taken one edge after the strobe.
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge sys_clk_i);
    {rd_o, addr_o} <= {1'b1, a};
    @(posedge sys_clk_i);
    {rd_o, addr_o} <= {1'b0, ~a};
    @(posedge sys_clk_i);
    d = rdata_i;
  endtask
endmodule

// *** pbcs_latch.sv ***
/*
 * Latching status bits: remote fault and jabber latch high, link latches
 * low; each returns to the live level on a status register read.
 * Assumes the condition inputs are synchronous to sys_clk_i.
 */
`timescale 1ns/100ps
module pbcs_latch
  import pbcs_pkg::*;
(
  input  wire logic   sys_clk_i,   // Management clock.
  input  wire logic   rstn_i,      // Asynchronous reset, active low.
  input  wire logic   soft_rst_i,  // Synchronous soft reset pulse.
  input  wire logic   rfault_i,    // Live remote fault condition.
  input  wire logic   jabber_i,    // Live jabber condition.
  input  wire logic   link_i,      // Live link state.
  pbcs_rd_if.latch    rd           // Read strobe and latched bits.
);

  logic rfault_q;
  logic jabber_q;
  logic link_q;

  // Latch high: the event wins over a read in the same cycle.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rfault_q <= 1'b0;
      jabber_q <= 1'b0;
    end else if (soft_rst_i) begin
      rfault_q <= 1'b0;
      jabber_q <= 1'b0;
    end else begin
      rfault_q <= rfault_i | (rfault_q & ~rd.stat_rd);
      jabber_q <= jabber_i | (jabber_q & ~rd.stat_rd);
    end
  end

  // Latch low: a loss holds zero until a read, which loads the live state.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      link_q <= 1'b0;
    end else if (soft_rst_i) begin
      link_q <= 1'b0;
    end else begin
      link_q <= link_i & (link_q | rd.stat_rd);
    end
  end

  assign rd.rfault = rfault_q;
  assign rd.jabber = jabber_q;
  assign rd.link   = link_q;

endmodule

// *** pbcs_pkg.sv ***
/*
 * Package for the basic control and status register bank of a 10/100
 * Ethernet transceiver: register indices, bit positions and reset values.
 * Assumes a single management clock domain shared by all users.
 */
package pbcs_pkg;

  // ****************************************************************
  // Register space
  // ****************************************************************
  localparam int unsigned ADDR_W  = 5;
  localparam int unsigned DATA_W  = 16;
  localparam logic [4:0]  REG_CTRL = 5'h00; // Basic control index.
  localparam logic [4:0]  REG_STAT = 5'h01; // Basic status index.
  localparam logic [4:0]  REG_STD_LAST = 5'h0f; // Last standard index.

  // ****************************************************************
  // Basic control bit positions
  // ****************************************************************
  localparam int unsigned C_RESET   = 15;
  localparam int unsigned C_LOOP    = 14;
  localparam int unsigned C_SPEED   = 13;
  localparam int unsigned C_ANEN    = 12;
  localparam int unsigned C_PDOWN   = 11;
  localparam int unsigned C_ISO     = 10;
  localparam int unsigned C_RESTART = 9;
  localparam int unsigned C_DUPLEX  = 8;
  localparam int unsigned C_COLTEST = 7;

  // ****************************************************************
  // Basic status bit positions and fixed values
  // ****************************************************************
  localparam int unsigned S_NOPRE  = 6;
  localparam int unsigned S_ANDONE = 5;
  localparam int unsigned S_RFAULT = 4;
  localparam int unsigned S_LINK   = 2;
  localparam int unsigned S_JABBER = 1;
  // Capability bits 15..11, 3 and 0 as fixed read-only values.
  localparam logic [15:0] STAT_CAPS = 16'h7809;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic RST_SPEED_NOSTRAP  = 1'b1;
  localparam logic RST_DUPLEX_NOSTRAP = 1'b1;
  localparam logic RST_NOPRE          = 1'b1;

endpackage

// *** pbcs_props.sv ***
/* Checker on the ports of the basic control and status bank.
   Assumes one clock domain with an asynchronous active-low reset. */
`timescale 1ns/100ps
module pbcs_props
  import pbcs_pkg::*;
(
  input wire logic        sys_clk_i,     // Clock.
  input wire logic        rstn_i,        // Reset.
  input wire logic        wr_i,          // Write.
  input wire logic        rd_i,          // Read.
  input wire logic [4:0]  addr_i,        // Index.
  input wire logic [15:0] wdata_i,       // Write data.
  input wire logic [15:0] rdata_o,       // Read data.
  input wire logic        vendor_loop_i, // Vendor loop.
  input wire logic        an_speed_i,    // Negotiated 100M.
  input wire logic        jabber_i,      // Jabber.
  input wire logic        link_i,        // Link.
  input wire logic        soft_rst_o,    // Soft reset.
  input wire logic        an_restart_o,  // Restart.
  input wire logic        loopback_o,    // Loopback.
  input wire logic        speed100_o,    // 100M.
  input wire logic        an_enable_o,   // Negotiation on.
  input wire logic        power_down_o,  // Power-down.
  input wire logic        std_hit_o      // Standard range.
);
  default clocking dc @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  logic ctl_on, rst_wr, stat_rd;
  // Control writes that take full effect, reset writes and status reads.
  assign ctl_on  = wr_i && addr_i == REG_CTRL && !power_down_o && !soft_rst_o;
  assign rst_wr  = wr_i && addr_i == REG_CTRL && wdata_i[C_RESET];
  assign stat_rd = rd_i && addr_i == REG_STAT && !soft_rst_o;

  AST_SOFT_RST:
    assert property (rst_wr && ctl_on |=> soft_rst_o)
    else $error("Soft reset pulse missing after a reset write.");
  AST_PDOWN_EXIT:
    assert property (rst_wr && power_down_o |=> !power_down_o && !soft_rst_o)
    else $error("First reset write in power-down misbehaved.");
  AST_RESTART:
    assert property (ctl_on && !rst_wr && wdata_i[C_RESTART] |=> an_restart_o)
    else $error("Restart pulse missing after a restart write.");
  AST_LOOP:
    assert property (loopback_o |-> vendor_loop_i)
    else $error("Loopback active without the vendor enable.");
  AST_NEG_SPEED:
    assert property (an_enable_o |-> speed100_o == an_speed_i)
    else $error("Speed does not follow the negotiated result.");
  AST_MANUAL:
    assert property (ctl_on && !rst_wr && !wdata_i[C_ANEN]
                     |=> speed100_o == $past(wdata_i[C_SPEED]))
    else $error("Manual speed not taken from the write.");
  AST_CAPS:
    assert property (stat_rd |=> rdata_o[15:11] == 5'h0f && rdata_o[3]
                     && rdata_o[0])
    else $error("Capability bits read wrong.");
  AST_JABBER:
    assert property (stat_rd && $past(jabber_i) && !$past(soft_rst_o)
                     |=> rdata_o[S_JABBER])
    else $error("Jabber event not latched high.");
  AST_LINK:
    assert property (stat_rd && !$past(link_i) && !$past(soft_rst_o)
                     |=> !rdata_o[S_LINK])
    else $error("Link loss not latched low.");
  AST_UNMAPPED:
    assert property (rd_i && addr_i > REG_STAT |=> rdata_o == 16'h0000)
    else $error("Read of an unused index returned data.");
  AST_STD_HIT:
    assert property (std_hit_o == (addr_i < 5'h10))
    else $error("Standard range flag wrong for the index.");
endmodule

// *** pbcs_rd_if.sv ***
/*
 * Interface carrying the read strobe of the status register from the
 * register bank to the latching status module, and the status back.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
interface pbcs_rd_if;
  logic       stat_rd;   // One-cycle pulse: status register read.
  logic       rfault;    // Latched-high remote fault.
  logic       jabber;    // Latched-high jabber.
  logic       link;      // Latched-low link status.

  modport bank (output stat_rd, input rfault, input jabber, input link);
  modport latch (input stat_rd, output rfault, output jabber, output link);
endinterface

// *** pbcs_regs.sv ***
/*
 * Basic control and status registers of a 10/100 Ethernet transceiver in
 * a 32-entry management register space, with strap-loaded defaults.
 * Assumes a management front end that presents one-cycle read and write
 * strobes with a 5-bit register index, synchronous to sys_clk_i.
 */
// Function
// - The space holds 32 entries, 0h-Fh standard and 10h-1Fh vendor.
// - Writing one to control bit 15 resets the block, then self-clears.
// - Loopback needs both control bit 14 and the vendor loopback enable.
// - Speed bit selects 100 or 10 Mbps and is ignored under negotiation.
// - Without a speed strap the speed bit resets to one; it is writable.
// - Negotiation result overrides manual bits; enable resets from strap.
// - From power-down, a first reset write clears it, a second resets.
// - The isolate bit disconnects the transceiver from the MII.
// - Writing one to restart negotiation restarts it, then self-clears.
// - Duplex bit selects full or half; resets to inverse of duplex strap, or to one without a strap.
// - Status reports fixed capabilities, T4 zero and the rest one.
// - The preamble suppression bit is writable and resets to one.
// - The completion bit reads one once negotiation is enabled and has finished.
// - Remote fault and jabber latch high until the status is read.

`timescale 1ns/100ps
module pbcs_regs
  import pbcs_pkg::*;
(
  input  wire logic              sys_clk_i,       // Management clock.
  input  wire logic              rstn_i,          // Async reset, low.
  input  wire logic              wr_i,            // Write strobe.
  input  wire logic              rd_i,            // Read strobe.
  input  wire logic [ADDR_W-1:0] addr_i,          // Register index.
  input  wire logic [DATA_W-1:0] wdata_i,         // Write data.
  output logic      [DATA_W-1:0] rdata_o,         // Read data.
  output logic                   std_hit_o,       // Index is standard.
  input  wire logic              has_strap_i,     // Strapped variant.
  input  wire logic              speed_strap_i,   // Speed strap level.
  input  wire logic              duplex_strap_i,  // Duplex strap level.
  input  wire logic              negotiation_strap_input, // Neg. strap.
  input  wire logic              vendor_loop_i,   // Vendor loop enable.
  input  wire logic              an_done_i,       // Negotiation done.
  input  wire logic              an_speed_i,      // Negotiated 100M.
  input  wire logic              an_duplex_i,     // Negotiated full.
  input  wire logic              rfault_i,        // Remote fault.
  input  wire logic              jabber_i,        // Jabber condition.
  input  wire logic              link_i,          // Live link state.
  output logic                   soft_rst_o,      // Soft reset pulse.
  output logic                   an_restart_o,    // Restart pulse.
  output logic                   loopback_o,      // Local loopback on.
  output logic                   speed100_o,      // Effective 100M.
  output logic                   full_duplex_o,   // Effective full.
  output logic                   an_enable_o,     // Negotiation on.
  output logic                   power_down_o,    // Power-down mode.
  output logic                   isolate_o,       // MII isolated.
  output logic                   col_test_o       // Collision test on.
);

  // ****************************************************************
  // Decode and strobes
  // ****************************************************************
  logic wr_ctrl;
  logic rst_req;
  logic soft_rst_q;
  logic straps_ok_q;

  // Index decode for the control register; standard range flag.
  assign wr_ctrl   = wr_i && (addr_i == REG_CTRL);
  assign std_hit_o = (addr_i <= REG_STD_LAST);
  assign rst_req   = wr_ctrl && wdata_i[C_RESET];

  pbcs_rd_if rdl ();
  assign rdl.stat_rd = rd_i && (addr_i == REG_STAT);

  pbcs_latch pbcs_latch_i (
    .sys_clk_i  (sys_clk_i),
    .rstn_i     (rstn_i),
    .soft_rst_i (soft_rst_q),
    .rfault_i   (rfault_i),
    .jabber_i   (jabber_i),
    .link_i     (link_i),
    .rd         (rdl.latch)
  );

  // ****************************************************************
  // Control register
  // ****************************************************************
  logic loop_q;
  logic speed_q;
  logic anen_q;
  logic pdown_q;
  logic iso_q;
  logic restart_q;
  logic duplex_q;
  logic coltest_q;
  logic nopre_q;

  // Soft reset pulse; a reset write while powered down only wakes.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= rst_req && !pdown_q;
    end
  end

  // Straps are caught one cycle after the reset release or a soft reset.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      straps_ok_q <= 1'b0;
    end else begin
      straps_ok_q <= !soft_rst_q;
    end
  end

  // Strap-dependent fields: loaded after reset, then writable.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      speed_q  <= RST_SPEED_NOSTRAP;
      duplex_q <= RST_DUPLEX_NOSTRAP;
      anen_q   <= 1'b0;
    end else if (!straps_ok_q) begin
      speed_q  <= has_strap_i ? speed_strap_i : RST_SPEED_NOSTRAP;
      duplex_q <= has_strap_i ? ~duplex_strap_i
                              : RST_DUPLEX_NOSTRAP;
      anen_q   <= negotiation_strap_input;
    end else if (wr_ctrl && !rst_req) begin
      speed_q  <= wdata_i[C_SPEED];
      duplex_q <= wdata_i[C_DUPLEX];
      anen_q   <= wdata_i[C_ANEN];
    end
  end

  // Plain fields; a reset write wakes from power-down or resets them.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      loop_q    <= 1'b0;
      pdown_q   <= 1'b0;
      iso_q     <= 1'b0;
      coltest_q <= 1'b0;
      nopre_q   <= RST_NOPRE;
    end else if (soft_rst_q) begin
      loop_q    <= 1'b0;
      pdown_q   <= 1'b0;
      iso_q     <= 1'b0;
      coltest_q <= 1'b0;
      nopre_q   <= RST_NOPRE;
    end else if (rst_req) begin
      pdown_q   <= 1'b0;
    end else if (wr_ctrl) begin
      loop_q    <= wdata_i[C_LOOP];
      pdown_q   <= wdata_i[C_PDOWN];
      iso_q     <= wdata_i[C_ISO];
      coltest_q <= wdata_i[C_COLTEST];
    end else if (wr_i && addr_i == REG_STAT) begin
      nopre_q   <= wdata_i[S_NOPRE];
    end
  end

  // Restart negotiation is a one-cycle pulse that reads back as zero.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      restart_q <= 1'b0;
    end else begin
      restart_q <= wr_ctrl && !rst_req && wdata_i[C_RESTART];
    end
  end

  // ****************************************************************
  // Effective mode outputs
  // ****************************************************************
  assign soft_rst_o    = soft_rst_q;
  assign an_restart_o  = restart_q;
  assign loopback_o    = loop_q && vendor_loop_i;
  assign speed100_o    = anen_q ? an_speed_i : speed_q;
  assign full_duplex_o = anen_q ? an_duplex_i : duplex_q;
  assign an_enable_o   = anen_q;
  assign power_down_o  = pdown_q;
  assign isolate_o     = iso_q;
  assign col_test_o    = coltest_q;

  // ****************************************************************
  // Read data
  // ****************************************************************
  logic [DATA_W-1:0] ctrl_v;
  logic [DATA_W-1:0] stat_v;

  // Assemble both registers; unlisted control bits stay zero, unlisted status bits come from STAT_CAPS.
  always_comb begin
    ctrl_v            = '0;
    ctrl_v[C_LOOP]    = loop_q;
    ctrl_v[C_SPEED]   = speed_q;
    ctrl_v[C_ANEN]    = anen_q;
    ctrl_v[C_PDOWN]   = pdown_q;
    ctrl_v[C_ISO]     = iso_q;
    ctrl_v[C_DUPLEX]  = duplex_q;
    ctrl_v[C_COLTEST] = coltest_q;
    stat_v            = STAT_CAPS;
    stat_v[S_NOPRE]   = nopre_q;
    stat_v[S_ANDONE]  = an_done_i && anen_q;
    stat_v[S_RFAULT]  = rdl.rfault;
    stat_v[S_LINK]    = rdl.link;
    stat_v[S_JABBER]  = rdl.jabber;
  end

  // Registered read data, sampled on the read strobe.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      unique case (addr_i)
        REG_CTRL: rdata_o <= ctrl_v;
        REG_STAT: rdata_o <= stat_v;
        default:  rdata_o <= '0;
      endcase
    end
  end

endmodule

// *** pbcs_regs_tb.sv ***
/* Self-checking bench for the basic control and status bank.
   Assumes the host model and the checker from this folder. */
`timescale 1ns/100ps
module pbcs_regs_tb;
  import pbcs_pkg::*;
  logic        sys_clk_i, rstn_i, wr_i, rd_i, has_strap_i, speed_strap_i;
  logic        duplex_strap_i, negotiation_strap_input, vendor_loop_i;
  logic        an_done_i, an_speed_i, an_duplex_i, rfault_i, jabber_i;
  logic        link_i, std_hit_o, soft_rst_o, an_restart_o, loopback_o;
  logic        speed100_o, full_duplex_o, an_enable_o, power_down_o;
  logic        isolate_o, col_test_o;
  logic [4:0]  addr_i;
  logic [15:0] wdata_i, rdata_o, v, outs;
  int          n_fail = 0;
  int          checks_done = 0;
  int          cyc = 0;

  // Bank under test and the host that drives it.
  pbcs_regs pbcs_regs_i (.sys_clk_i, .rstn_i, .wr_i, .rd_i, .addr_i,
    .wdata_i, .rdata_o, .std_hit_o, .has_strap_i, .speed_strap_i,
    .duplex_strap_i, .negotiation_strap_input, .vendor_loop_i, .an_done_i,
    .an_speed_i, .an_duplex_i, .rfault_i, .jabber_i, .link_i, .soft_rst_o,
    .an_restart_o, .loopback_o, .speed100_o, .full_duplex_o, .an_enable_o,
    .power_down_o, .isolate_o, .col_test_o);
  pbcs_host pbcs_host_i (.sys_clk_i, .rdata_i(rdata_o), .wr_o(wr_i),
    .rd_o(rd_i), .addr_o(addr_i), .wdata_o(wdata_i));
  // Mode outputs gathered into one word for comparison.
  assign outs = {9'h000, loopback_o, speed100_o, full_duplex_o, an_enable_o,
                 power_down_o, isolate_o, col_test_o};

  // Clock, and a cycle ceiling that cuts a hang short.
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      results();
    end
  end

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [4:0] a, input logic [15:0] exp);
    pbcs_host_i.rd(a, v);
    chk(v, exp);
  endtask
  // Outputs are compared once the write edge has settled.
  task automatic co(input logic [15:0] exp);
    @(negedge sys_clk_i);
    chk(outs, exp);
  endtask
  task automatic rst();
    @(posedge sys_clk_i) rstn_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
  endtask

  // Unstrapped variant first, then a strapped one after a second reset.
  initial begin
    {rstn_i, has_strap_i, speed_strap_i, duplex_strap_i} = 4'h0;
    {negotiation_strap_input, vendor_loop_i, an_done_i} = 3'h0;
    {an_speed_i, an_duplex_i, rfault_i, jabber_i, link_i} = 5'h01;
    rst();
    rc(REG_CTRL, 16'h2100);
    co(16'h0030);
    pbcs_host_i.rd(REG_STAT, v);
    rc(REG_STAT, 16'h784d);
    pbcs_host_i.wr(REG_CTRL, 16'h65ff);
    co(16'h0033);
    rc(REG_CTRL, 16'h6580);
    @(posedge sys_clk_i) vendor_loop_i <= 1'b1;
    co(16'h0073);
    pbcs_host_i.wr(REG_CTRL, 16'h0200);
    co(16'h0000);
    rc(REG_CTRL, 16'h0000);
    pbcs_host_i.wr(REG_STAT, 16'hffbf);
    rc(REG_STAT, 16'h780d);
    @(posedge sys_clk_i) {jabber_i, rfault_i, link_i} <= 3'b110;
    fork
      rc(REG_STAT, 16'h781b);
      @(posedge sys_clk_i) {jabber_i, rfault_i, link_i} <= 3'b001;
    join
    rc(REG_STAT, 16'h780d);
    pbcs_host_i.wr(5'h10, 16'hffff);
    rc(5'h10, 16'h0000);
    pbcs_host_i.wr(REG_CTRL, 16'h0800);
    co(16'h0004);
    pbcs_host_i.wr(REG_CTRL, 16'h8000);
    co(16'h0000);
    pbcs_host_i.wr(REG_CTRL, 16'h8000);
    repeat (3) @(posedge sys_clk_i);
    rc(REG_CTRL, 16'h2100);
    pbcs_host_i.rd(REG_STAT, v);
    rc(REG_STAT, 16'h784d);
    @(posedge sys_clk_i) begin
      {has_strap_i, duplex_strap_i, negotiation_strap_input} <= 3'h7;
      an_done_i <= 1'b1;
    end
    rst();
    rc(REG_CTRL, 16'h1000);
    co(16'h0008);
    pbcs_host_i.wr(REG_CTRL, 16'h3300);
    co(16'h0008);
    pbcs_host_i.rd(REG_STAT, v);
    rc(REG_STAT, 16'h786d);
    results();
  end
endmodule

bind pbcs_regs pbcs_props pbcs_props_i (.sys_clk_i, .rstn_i, .wr_i, .rd_i,
  .addr_i, .wdata_i, .rdata_o, .vendor_loop_i, .an_speed_i, .jabber_i,
  .link_i, .soft_rst_o, .an_restart_o, .loopback_o, .speed100_o,
  .an_enable_o, .power_down_o, .std_hit_o);
